// *** logic/interval_timer_pkg.sv ***
// constants, mode codes and state layout of the three-channel interval timer
package interval_timer_pkg;

  localparam int NUM_CNT = 3;
  localparam int DIGIT_W = 4;
  localparam int NUM_DIGITS = 4;

  // register port addresses; counters sit at their own index
  localparam logic [1:0] ADDR_CONTROL = 2'h3;

  // control word fields
  localparam int CW_SEL_HI = 7;
  localparam int CW_SEL_LO = 6;
  localparam int CW_FMT_HI = 5;
  localparam int CW_FMT_LO = 4;
  localparam int CW_MODE_HI = 3;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD = 0;
  localparam logic [1:0] SEL_ILLEGAL = 2'h3;

  // read/load formats
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LOW = 2'h1;
  localparam logic [1:0] FMT_HIGH = 2'h2;
  localparam logic [1:0] FMT_BOTH = 2'h3;

  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam logic [3:0] DIGIT_NINE = 4'h9;
  localparam logic [3:0] DIGIT_ONE = 4'h1;
  localparam logic [4:0] BCD_TEN = 5'h0a;

  // fastest count clock; the three-stage sampler needs it well below clk
  localparam int CNT_CLK_MAX_KHZ = 2000;
  localparam int SYS_CLK_KHZ = 250000;
  localparam int CNT_CLK_MIN_CYCLES = SYS_CLK_KHZ / CNT_CLK_MAX_KHZ;

  typedef enum logic [5:0] {
    MODE_INT      = 6'h01,
    MODE_ONESHOT  = 6'h02,
    MODE_RATE     = 6'h04,
    MODE_SQUARE   = 6'h08,
    MODE_SW_STROBE = 6'h10,
    MODE_HW_STROBE = 6'h20
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic [1:0] fmt;
    logic bcd;
    logic [15:0] count;
    logic [15:0] cur_n;
    logic [15:0] load_val;
    logic [15:0] latch_val;
    logic latched;
    logic wr_hi;
    logic rd_hi;
    logic armed;
    logic pending;
    logic gate_rise;
    logic out;
    logic [2:0] ck_sync;
    logic ck_lvl;
    logic [2:0] gt_sync;
    logic gt_lvl;
  } chan_t;

  typedef struct packed {
    chan_t [NUM_CNT-1:0] ch;
    logic wr_idle;
    logic rd_idle;
    logic [7:0] dout;
    logic doe;
  } state_t;

  function automatic logic [15:0] count_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v - COUNT_ONE;
    if (bcd)
    begin
      r = v;
      borrow = 1'b1;
      for (int k = 0; k < NUM_DIGITS; k++)
      begin
        if (borrow)
        begin
          if (v[k*DIGIT_W +: DIGIT_W] == DIGIT_ZERO)
            r[k*DIGIT_W +: DIGIT_W] = DIGIT_NINE;
          else
          begin
            r[k*DIGIT_W +: DIGIT_W] = v[k*DIGIT_W +: DIGIT_W] - DIGIT_ONE;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : count_dec

  // floor(v/2) in the counter's own number system, for the square-wave split
  function automatic logic [15:0] count_half(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic rem;
    logic [4:0] t;
    r = v >> 1;
    rem = 1'b0;
    t = 5'h00;
    if (bcd)
    begin
      for (int k = NUM_DIGITS - 1; k >= 0; k--)
      begin
        t = (rem ? BCD_TEN : 5'h00) + {1'b0, v[k*DIGIT_W +: DIGIT_W]};
        r[k*DIGIT_W +: DIGIT_W] = t[4:1];
        rem = t[0];
      end
    end
    return r;
  endfunction : count_half

  function automatic mode_t mode_decode(input logic [2:0] m);
    mode_t r;
    if (m[1])
      r = m[0] ? MODE_SQUARE : MODE_RATE;
    else
    begin
      case ({m[2], m[0]})
        2'b00: r = MODE_INT;
        2'b01: r = MODE_ONESHOT;
        2'b10: r = MODE_SW_STROBE;
        default: r = MODE_HW_STROBE;
      endcase
    end
    return r;
  endfunction : mode_decode

endpackage : interval_timer_pkg

// *** logic/triple_interval_timer.sv ***
// three 16-bit down counters behind an 8-bit register port
`timescale 1ns/1ns

// Notes on behaviour
// - three independent 16-bit counters, each on its own count clock up to 2 MHz
// - control word: bits 7-6 counter, 5-4 format, 3-1 mode, 0 BCD
// - select 00/01/10 picks counter 0/1/2; 11 is illegal and ignored
// - BCD bit 0 counts binary, 1 counts four BCD decades
// - format 00 latches, 01 low byte, 10 high byte, 11 low then high
// - mode bits 000,001,x10,x11,100,101 give modes 0 to 5
// - address 00-10 picks a counter, 11 the control word, only with select
// - mode 0 output low while counting, high at terminal count, gate low pauses
// - mode 0 reload: first byte halts, second byte starts the new count
// - mode 1 gate rise drives output low until terminal count; reload waits
// - mode 1 retriggers on every gate rise, restarting the full count
// - mode 2 divides by N with a one-period low; gate low holds high
// - mode 2 output high until loaded; a reload acts at the end of the current period
// - mode 3 square wave of period N; odd N high (N+1)/2, low (N-1)/2
// - mode 3 reload takes effect at the end of the current period
// - mode 4 output high, count starts at load, gate pauses, one-period low pulse
// - mode 4 reload restarts counting from the new value
// - mode 5 starts on gate rise, one-period low pulse, retriggerable
// - all counters count down from the loaded value
// - after a latch, reads give the frozen count in the set format; format 11 gives low byte then high byte
module triple_interval_timer
  import interval_timer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port, synchronous to clk
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // counter pins
  input wire logic [NUM_CNT-1:0] counter_clock_inputs,
  input wire logic [NUM_CNT-1:0] gate_in,
  output logic [NUM_CNT-1:0] cnt_out
);

  state_t st_reg;
  state_t st_next;

  always_comb
  begin
    chan_t c;
    logic tick;
    logic trig;
    logic gate;
    logic done;
    logic last;
    logic wr_go;
    logic rd_go;
    logic [15:0] dec;
    logic [15:0] nxt;
    logic [15:0] src;
    logic [1:0] sel;
    c = '0;
    tick = 1'b0;
    trig = 1'b0;
    gate = 1'b0;
    done = 1'b0;
    last = 1'b0;
    dec = '0;
    nxt = '0;
    src = '0;
    st_next = st_reg;
    sel = data_in[CW_SEL_HI:CW_SEL_LO];
    // one action per strobe: taken on the first cycle it is seen active
    wr_go = ~cs_n & ~wr_n & st_reg.wr_idle;
    rd_go = ~cs_n & ~rd_n & st_reg.rd_idle;
    st_next.wr_idle = ~(~cs_n & ~wr_n);
    st_next.rd_idle = ~(~cs_n & ~rd_n);
    st_next.doe = ~cs_n & ~rd_n;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      c = st_reg.ch[i];
      tick = 1'b0;
      // count clock: a level counts once the second and third stages agree
      c.ck_sync = {st_reg.ch[i].ck_sync[1:0], counter_clock_inputs[i]};
      if (st_reg.ch[i].ck_sync[1] == st_reg.ch[i].ck_sync[2])
      begin
        c.ck_lvl = st_reg.ch[i].ck_sync[2];
        tick = st_reg.ch[i].ck_sync[2] & ~st_reg.ch[i].ck_lvl;
      end
      gate = st_reg.ch[i].gt_lvl;
      trig = st_reg.ch[i].gate_rise;
      dec = count_dec(st_reg.ch[i].count, st_reg.ch[i].bcd);
      if (tick)
      begin
        c.gate_rise = 1'b0;
        case (st_reg.ch[i].mode)
          MODE_INT:
          begin
            if (st_reg.ch[i].pending)
            begin
              c.count = st_reg.ch[i].load_val;
              c.armed = 1'b1;
              c.pending = 1'b0;
            end
            else if (st_reg.ch[i].armed && gate)
            begin
              c.count = dec;
              if (st_reg.ch[i].count == COUNT_ONE)
                c.out = 1'b1;
            end
          end
          MODE_ONESHOT:
          begin
            if (trig)
            begin
              // a load during the pulse only shows at the next trigger
              c.count = st_reg.ch[i].load_val;
              c.armed = 1'b1;
              c.out = 1'b0;
            end
            else if (st_reg.ch[i].armed)
            begin
              c.count = dec;
              if (st_reg.ch[i].count == COUNT_ONE)
              begin
                c.out = 1'b1;
                c.armed = 1'b0;
              end
            end
          end
          MODE_RATE:
          begin
            if (!gate)
              c.out = 1'b1;
            else if (trig || (st_reg.ch[i].pending && !st_reg.ch[i].armed))
            begin
              c.count = st_reg.ch[i].load_val;
              c.armed = 1'b1;
              c.pending = 1'b0;
              c.out = 1'b1;
            end
            else if (st_reg.ch[i].armed)
            begin
              if (st_reg.ch[i].count == COUNT_ONE)
              begin
                // reload only at the period boundary
                c.count = st_reg.ch[i].load_val;
                c.pending = 1'b0;
                c.out = 1'b1;
              end
              else
              begin
                c.count = dec;
                c.out = (dec != COUNT_ONE);
              end
            end
          end
          MODE_SQUARE:
          begin
            if (!gate)
              c.out = 1'b1;
            else if (trig || (st_reg.ch[i].pending && !st_reg.ch[i].armed))
            begin
              c.count = st_reg.ch[i].load_val;
              c.cur_n = st_reg.ch[i].load_val;
              c.armed = 1'b1;
              c.pending = 1'b0;
              c.out = 1'b1;
            end
            else if (st_reg.ch[i].armed)
            begin
              nxt = dec;
              if (st_reg.ch[i].count == COUNT_ONE)
              begin
                // the period end is an output transition, so a new count lands here
                nxt = st_reg.ch[i].load_val;
                c.cur_n = st_reg.ch[i].load_val;
                c.pending = 1'b0;
              end
              c.count = nxt;
              c.out = nxt > count_half(c.cur_n, st_reg.ch[i].bcd);
            end
          end
          MODE_SW_STROBE:
          begin
            if (st_reg.ch[i].pending)
            begin
              c.count = st_reg.ch[i].load_val;
              c.armed = 1'b1;
              c.pending = 1'b0;
              c.out = 1'b1;
            end
            else if (!st_reg.ch[i].out)
              c.out = 1'b1;
            else if (st_reg.ch[i].armed && gate)
            begin
              c.count = dec;
              if (st_reg.ch[i].count == COUNT_ONE)
              begin
                c.out = 1'b0;
                c.armed = 1'b0;
              end
            end
          end
          MODE_HW_STROBE:
          begin
            if (trig)
            begin
              c.count = st_reg.ch[i].load_val;
              c.armed = 1'b1;
              c.out = 1'b1;
            end
            else if (!st_reg.ch[i].out)
              c.out = 1'b1;
            else if (st_reg.ch[i].armed)
            begin
              c.count = dec;
              if (st_reg.ch[i].count == COUNT_ONE)
              begin
                c.out = 1'b0;
                c.armed = 1'b0;
              end
            end
          end
          default:
          begin
            c.armed = 1'b0;
          end
        endcase
      end
      // gate sampler; a rise seen in the tick cycle survives the clear
      c.gt_sync = {st_reg.ch[i].gt_sync[1:0], gate_in[i]};
      if (st_reg.ch[i].gt_sync[1] == st_reg.ch[i].gt_sync[2])
      begin
        c.gt_lvl = st_reg.ch[i].gt_sync[2];
        if (st_reg.ch[i].gt_sync[2] && !st_reg.ch[i].gt_lvl)
          c.gate_rise = 1'b1;
      end
      // control word
      if (wr_go && addr == ADDR_CONTROL && sel != SEL_ILLEGAL && sel == 2'(i))
      begin
        if (data_in[CW_FMT_HI:CW_FMT_LO] == FMT_LATCH)
        begin
          if (!c.latched)
            c.latch_val = c.count;
          c.latched = 1'b1;
          c.rd_hi = 1'b0;
        end
        else
        begin
          c.mode = mode_decode(data_in[CW_MODE_HI:CW_MODE_LO]);
          c.fmt = data_in[CW_FMT_HI:CW_FMT_LO];
          c.bcd = data_in[CW_BCD];
          c.armed = 1'b0;
          c.pending = 1'b0;
          c.wr_hi = 1'b0;
          c.rd_hi = 1'b0;
          c.latched = 1'b0;
          // a gate already high before the mode write is no trigger; a rise this cycle still counts
          c.gate_rise = c.gt_lvl & ~st_reg.ch[i].gt_lvl;
          // mode 0 starts low; every other mode idles high until loaded
          c.out = (c.mode != MODE_INT);
        end
      end
      // count bytes
      done = 1'b0;
      if (wr_go && addr == 2'(i))
      begin
        case (c.fmt)
          FMT_LOW:
          begin
            c.load_val = {BYTE_ZERO, data_in};
            done = 1'b1;
          end
          FMT_HIGH:
          begin
            c.load_val = {data_in, BYTE_ZERO};
            done = 1'b1;
          end
          FMT_BOTH:
          begin
            if (!c.wr_hi)
            begin
              c.load_val[7:0] = data_in;
              c.wr_hi = 1'b1;
              if (c.mode == MODE_INT)
                c.armed = 1'b0;
            end
            else
            begin
              c.load_val[15:8] = data_in;
              c.wr_hi = 1'b0;
              done = 1'b1;
            end
          end
          default:
          begin
            done = 1'b0;
          end
        endcase
        if (done)
        begin
          c.pending = 1'b1;
          if (c.mode == MODE_INT)
          begin
            c.out = 1'b0;
            c.armed = 1'b0;
          end
        end
      end
      // reads: latched value until every byte of the format is taken
      if (rd_go && addr == 2'(i))
      begin
        src = c.latched ? c.latch_val : c.count;
        last = 1'b1;
        case (c.fmt)
          FMT_HIGH:
            st_next.dout = src[15:8];
          FMT_BOTH:
          begin
            st_next.dout = c.rd_hi ? src[15:8] : src[7:0];
            last = c.rd_hi;
            c.rd_hi = ~c.rd_hi;
          end
          default:
            st_next.dout = src[7:0];
        endcase
        if (last)
          c.latched = 1'b0;
      end
      st_next.ch[i] = c;
    end
    // the control word is write-only; reading it gives zero
    if (rd_go && addr == ADDR_CONTROL)
      st_next.dout = BYTE_ZERO;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign data_out = st_reg.dout;
  assign data_oe = st_reg.doe;

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++)
    begin : g_out
      assign cnt_out[g] = st_reg.ch[g].out;
    end
  endgenerate

endmodule : triple_interval_timer

// *** bench/triple_interval_timer_monitor.sv ***
// checker for the interval timer register port and counter outputs
`timescale 1ns/1ns
module triple_interval_timer_monitor
  import interval_timer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  // counter pins
  input wire logic [NUM_CNT-1:0] counter_clock_inputs,
  input wire logic [NUM_CNT-1:0] gate_in,
  input wire logic [NUM_CNT-1:0] cnt_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // an access counts only on the first cycle of its strobe
  sequence rd_take;
    !cs_n && !rd_n && $past(cs_n || rd_n);
  endsequence
  sequence ctl_take;
    !cs_n && !wr_n && $past(cs_n || wr_n) && addr == ADDR_CONTROL;
  endsequence
  // count clocks low and no writes: the last tick has long since landed
  sequence idle_pins;
    !(|counter_clock_inputs) && wr_n;
  endsequence
  chk_oe_follows: assert property (!cs_n && !rd_n |=> data_oe)
    else $error("bus not driven after read strobe");
  chk_oe_release: assert property (cs_n || rd_n |=> !data_oe)
    else $error("bus still driven without read strobe");
  chk_ctl_reads_zero: assert property (rd_take ##0 addr == ADDR_CONTROL |=> data_out == BYTE_ZERO)
    else $error("control address read not zero");
  chk_data_holds: assert property (cs_n || rd_n |=> $stable(data_out))
    else $error("read data moved without a read");
  chk_quiet_outs: assert property (idle_pins [*8] |=> $stable(cnt_out))
    else $error("output moved without tick or write");
  chk_bad_select: assert property (ctl_take ##0 data_in[7:6] == SEL_ILLEGAL |=> $stable(cnt_out) [*3])
    else $error("illegal select changed an output");
  chk_mode0_low: assert property (ctl_take ##0 data_in[7:6] == 2'h1 && data_in[5:4] != FMT_LATCH
    && data_in[3:1] == 3'h0 |-> ##[1:3] !cnt_out[1])
    else $error("mode 0 set left output high");
  chk_mode_high: assert property (ctl_take ##0 data_in[7:6] == 2'h1 && data_in[5:4] != FMT_LATCH
    && (data_in[2:1] == 2'h2 || data_in[3:1] == 3'h4) |-> ##[1:3] cnt_out[1])
    else $error("mode 2 or 4 set left output low");
endmodule : triple_interval_timer_monitor

bind triple_interval_timer triple_interval_timer_monitor mon (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
  .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .counter_clock_inputs(counter_clock_inputs), .gate_in(gate_in), .cnt_out(cnt_out));

// *** bench/host_bus_model.sv ***
// host processor model driving the timer register port
`timescale 1ns/1ns
module host_bus_model
  import interval_timer_pkg::*;
(
  // clock
  input wire logic clk,
  // register port toward the timer
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [1:0] addr,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out
);
  initial {cs_n, rd_n, wr_n, addr, data_in} = {3'h7, 2'h0, 8'h00};

  // idle bus carries inverted junk so stale values never look valid
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    {cs_n, wr_n, addr, data_in} = {2'h0, a, d};
    @(negedge clk);
    {cs_n, wr_n, addr, data_in} = {2'h3, ~a, ~d};
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge clk);
    {cs_n, rd_n, addr} = {2'h0, a};
    @(negedge clk);
    d = data_out;
    {cs_n, rd_n, addr} = {2'h3, ~a};
  endtask : rd

  // control word first, then the count bytes low before high
  task automatic cfg(input logic [1:0] c, input logic [1:0] fmt, input logic [2:0] md, input logic bcd,
    input logic [15:0] n);
    wr(ADDR_CONTROL, {c, fmt, md, bcd});
    if (fmt[0]) wr(c, n[7:0]);
    if (fmt[1]) wr(c, n[15:8]);
  endtask : cfg

  function automatic int serial_div(input int rate);
    return 125000 / rate;
  endfunction : serial_div
endmodule : host_bus_model

// *** bench/triple_interval_timer_tb.sv ***
// self-checking bench for the interval timer
`timescale 1ns/1ns
module triple_interval_timer_tb
  import interval_timer_pkg::*;
;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [2:0] clk_pins = 3'h0;
  logic [2:0] gate_pins = 3'h7;
  logic cs_n, rd_n, wr_n, data_oe;
  logic [1:0] addr;
  logic [7:0] data_in, data_out, rv;
  logic [2:0] cnt_out;
  int fail_count = 0, checks_done = 0, cycles = 0, seed = 50, n0, lv;
  int codes[5] = '{2, 0, 4, 0, 6};
  int m_cnt[3], m_n[3], m_mode[3];
  bit m_out[3], m_pend[3], m_arm[3], m_trig[3];

  always #2 clk = ~clk;

  host_bus_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
    .data_out(data_out));
  triple_interval_timer dut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .counter_clock_inputs(clk_pins),
    .gate_in(gate_pins), .cnt_out(cnt_out));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      $display("MISMATCH at %0t: run too long", $time);
      end_of_test;
    end
  end

  // reference counter, one step per count clock tick
  task automatic mtick(input int c);
    // gate-started modes: a load waits for the next trigger
    if (m_mode[c] == 1 || m_mode[c] == 5)
    begin
      if (m_trig[c])
      begin
        m_cnt[c] = m_n[c];
        m_arm[c] = 1;
        m_trig[c] = 0;
        m_out[c] = (m_mode[c] == 5);
      end
      else if (!m_out[c] && m_mode[c] == 5)
        m_out[c] = 1;
      else if (m_arm[c])
      begin
        m_cnt[c]--;
        if (m_cnt[c] == 0)
        begin
          m_arm[c] = 0;
          m_out[c] = (m_mode[c] == 1);
        end
      end
      return;
    end
    if (m_pend[c])
    begin
      m_cnt[c] = m_n[c];
      m_pend[c] = 0;
      m_arm[c] = 1;
    end
    else if (m_mode[c] == 4)
    begin
      if (!m_out[c]) m_arm[c] = 0;
      else if (m_arm[c]) m_cnt[c]--;
    end
    else if (m_mode[c] == 0)
      m_cnt[c] -= (gate_pins[c] && m_cnt[c] > 0);
    else
      m_cnt[c] = (m_cnt[c] == 1) ? m_n[c] : m_cnt[c] - 1;
    case (m_mode[c])
      0: m_out[c] = (m_cnt[c] == 0);
      2: m_out[c] = (m_cnt[c] != 1);
      3: m_out[c] = (m_cnt[c] > m_n[c] / 2);
      default: m_out[c] = !(m_arm[c] && m_cnt[c] == 0);
    endcase
  endtask : mtick

  // about 1.98 MHz, just inside the fastest allowed count clock
  task automatic tick(input int c);
    @(negedge clk);
    clk_pins[c] = 1'h1;
    repeat (62) @(negedge clk);
    clk_pins[c] = 1'h0;
    repeat (63) @(negedge clk);
    mtick(c);
    check(cnt_out[c], m_out[c]);
  endtask : tick

  // low then high on the gate, long enough for the sampler to see both levels
  task automatic trigger(input int c);
    gate_pins[c] = 1'h0;
    repeat (8) @(negedge clk);
    gate_pins[c] = 1'h1;
    repeat (8) @(negedge clk);
    m_trig[c] = 1;
  endtask : trigger

  task automatic setup(input int c, input int md, input logic bcd, input logic [1:0] fmt, input int val);
    host.cfg(c[1:0], fmt, md[2:0], bcd, val[15:0]);
    m_mode[c] = md;
    m_n[c] = val;
    m_pend[c] = 1;
    m_out[c] = (md != 0);
    m_arm[c] = 0;
    m_trig[c] = 0;
  endtask : setup

  initial
  begin
    repeat (10) @(negedge clk);
    sys_rst = 1'h0;
    n0 = 2 + ($unsigned($random(seed)) % 4);
    setup(0, 4, 1'h0, FMT_LOW, n0);
    repeat (n0 + 3) tick(0);
    host.wr(ADDR_CONTROL, 8'hc0);
    repeat (4) @(negedge clk);
    check(cnt_out, {m_out[2], m_out[1], m_out[0]});
    host.rd(ADDR_CONTROL, rv);
    check(rv, BYTE_ZERO);
    foreach (codes[i])
    begin
      host.wr(ADDR_CONTROL, {2'h1, FMT_HIGH, codes[i][2:0], 1'h0});
      repeat (3) @(negedge clk);
      check(cnt_out[1], codes[i] != 0);
    end
    n0 = host.serial_div(31250);
    setup(1, 2, 1'h0, FMT_LOW, n0);
    repeat (6) tick(1);
    setup(1, 3, 1'h0, FMT_LOW, 5);
    repeat (7) tick(1);
    setup(1, 1, 1'h0, FMT_LOW, 3);
    tick(1);
    trigger(1);
    repeat (2) tick(1);
    trigger(1);
    repeat (5) tick(1);
    setup(1, 5, 1'h0, FMT_LOW, 2);
    trigger(1);
    repeat (4) tick(1);
    // bcd load of 0x0100 must step to 0x0099, not 0x00ff
    host.cfg(2'h2, FMT_BOTH, 3'h0, 1'h1, 16'h0100);
    m_mode[2] = 0;
    m_n[2] = 100;
    m_pend[2] = 1;
    m_out[2] = 0;
    repeat (2) tick(2);
    host.cfg(2'h2, FMT_LATCH, 3'h0, 1'h0, 16'h0000);
    lv = ((m_cnt[2] / 100) << 8) | ((m_cnt[2] % 100 / 10) << 4) | (m_cnt[2] % 10);
    tick(2);
    host.rd(2'h2, rv);
    check(rv, lv[7:0]);
    host.rd(ADDR_CONTROL, rv);
    check(rv, BYTE_ZERO);
    host.rd(2'h2, rv);
    check(rv, lv[15:8]);
    gate_pins[2] = 1'h0;
    repeat (8) @(negedge clk);
    tick(2);
    gate_pins[2] = 1'h1;
    repeat (99) tick(2);
    end_of_test;
  end
endmodule : triple_interval_timer_tb
